// ==== logic/sadc_ctrl_shift.sv ====
// Control word capture from the serial data input.
// Assumes rise strobes mark serial clock rising edges inside a frame.
`timescale 1ns/10ps
module sadc_ctrl_shift (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic frame_start, // Pulse at chip select fall
  input wire logic sclk_rise, // Rising edge in frame
  input wire logic din, // Serial data input
  output logic [2:0] next_chan, // Channel captured for next slot
  output logic word_done // Pulse when eight bits taken
);

  logic [7:0] shift_q;
  logic [3:0] count_q;

  always_ff @(posedge core_clk) begin
    if (rst || frame_start) begin
      count_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (sclk_rise &&
                 count_q < 4'(sadc_pkg::CTRL_BITS)) begin
      count_q <= count_q + 4'h1;
      shift_q <= {shift_q[6:0], din};
    end
  end

  assign word_done = sclk_rise &&
                     count_q == 4'(sadc_pkg::CTRL_BITS - 1);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      next_chan <= sadc_pkg::CHAN_RESET;
    end else if (word_done) begin
      // Bits 7 to 1 sit in shift_q[6:0] at the eighth rise
      next_chan <= shift_q[sadc_pkg::CHAN_MSB - 1:
                           sadc_pkg::CHAN_LSB - 1];
    end
  end

endmodule

// ==== logic/sadc_edge_det.sv ====
// Edge detector for the serial clock and chip select pins.
// Assumes pins are synchronous to core_clk.
`timescale 1ns/10ps
module sadc_edge_det (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic pin, // Sampled pin
  output logic rise, // Rising edge pulse
  output logic fall, // Falling edge pulse
  output logic prev // Previous pin level
);

  logic last_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_q <= 1'b1;
    end else begin
      last_q <= pin;
    end
  end

  assign rise = pin & ~last_q;
  assign fall = ~pin & last_q;
  assign prev = last_q;

endmodule

// ==== logic/sadc_frame_seq.sv ====
// Frame and conversion sequencer of an eight-channel 8-bit converter.
// Assumes sclk, cs_n and din are synchronous to core_clk and that the
// analog core returns a result when its hold phase starts.
// Overview of operation
// - Track the selected input for the first three clocks of a slot.
// - Hold and convert for the next twelve clocks while shifting out.
// - A frame runs from chip select falling to chip select rising.
// - Data out is released while chip select is high, driven when low.
// - Serial clock edges are ignored while chip select is high.
// - Falls 1-4 give zeros, 5-12 the result MSB first, 13-16 zeros.
// - Tracking resumes after each sixteenth rise; hold on fourth fall.
// - Chip select falling with clock high: track on next clock fall.
// - Chip select falling with clock low counts as the first fall.
// - Chip select and clock falling together start the first slot.
// - Next channel is taken from data in on the first eight rises of a frame.
// - A conversion start follows the previous one by sixteen clocks.
// - The first conversion after power-up uses channel zero.
// - Channel number sits in control bits 5 to 3; others ignored.
// - Power down between fall sixteen and next fall one, or cs high.
`timescale 1ns/10ps
module sadc_frame_seq (
  input wire logic core_clk, // Core clock, 200 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic cs_n, // Chip select, active low
  input wire logic sclk, // Serial clock from host
  input wire logic din, // Serial data input
  output logic dout_o, // Serial data output value
  output logic dout_oe, // Serial data output enable
  input wire logic [7:0] conv_result, // Result from analog core
  output logic [2:0] analog_input_channels, // Channel to mux
  output logic track_en, // Sampling switch closed
  output logic hold_en, // Hold and convert active
  output logic conv_start, // Pulse at start of hold
  output logic powered_up // Analog core powered
);

  // ===========================================================
  // Pin edges
  logic cs_fall;
  logic sck_rise, sck_fall;

  sadc_edge_det u_cs_edge (
    .core_clk(core_clk),
    .rst(rst),
    .pin(cs_n),
    .rise(),
    .fall(cs_fall),
    .prev()
  );

  sadc_edge_det u_sck_edge (
    .core_clk(core_clk),
    .rst(rst),
    .pin(sclk),
    .rise(sck_rise),
    .fall(sck_fall),
    .prev()
  );

  // Clock edges count only inside a frame
  logic in_frame;
  logic f_rise, f_fall;
  assign in_frame = ~cs_n & ~cs_fall;
  assign f_rise = sck_rise & in_frame;
  assign f_fall = sck_fall & in_frame;

  // First fall: low clock at cs fall, or both falling together
  logic start_now;
  assign start_now = cs_fall & ~sclk;

  // ===========================================================
  // Control word capture
  logic [2:0] next_chan;

  sadc_ctrl_shift u_ctrl (
    .core_clk(core_clk),
    .rst(rst),
    .frame_start(cs_fall),
    .sclk_rise(f_rise),
    .din(din),
    .next_chan(next_chan),
    .word_done()
  );

  // ===========================================================
  // Slot counters
  logic [4:0] fall_cnt_q;
  logic [4:0] rise_cnt_q;
  sadc_pkg::sadc_phase_t phase_q;

  always_ff @(posedge core_clk) begin
    if (rst || cs_n) begin
      rise_cnt_q <= 5'h0;
    end else if (f_rise) begin
      if (rise_cnt_q == 5'(sadc_pkg::SLOT_EDGES)) begin
        rise_cnt_q <= 5'h1;
      end else begin
        rise_cnt_q <= rise_cnt_q + 5'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || cs_n) begin
      fall_cnt_q <= 5'h0;
    end else if (start_now) begin
      fall_cnt_q <= 5'h1;
    end else if (f_fall) begin
      if (fall_cnt_q == 5'(sadc_pkg::SLOT_EDGES) &&
          rise_cnt_q == 5'(sadc_pkg::SLOT_EDGES)) begin
        fall_cnt_q <= 5'h1;
      end else if (fall_cnt_q < 5'(sadc_pkg::SLOT_EDGES)) begin
        fall_cnt_q <= fall_cnt_q + 5'h1;
      end
    end
  end

  // ===========================================================
  // Phase sequencing
  logic enter_track, enter_hold, slot_end;
  assign enter_track = start_now ||
                       (f_fall && (fall_cnt_q == 5'h0 ||
                        (fall_cnt_q == 5'(sadc_pkg::SLOT_EDGES) &&
                         rise_cnt_q == 5'(sadc_pkg::SLOT_EDGES))));
  assign enter_hold = f_fall &&
    fall_cnt_q == 5'(sadc_pkg::HOLD_START_FALL - 1);
  assign slot_end = f_fall &&
    fall_cnt_q == 5'(sadc_pkg::SLOT_EDGES - 1);

  always_ff @(posedge core_clk) begin
    if (rst || cs_n) begin
      phase_q <= sadc_pkg::SADC_IDLE;
    end else begin
      unique case (phase_q)
        sadc_pkg::SADC_IDLE, sadc_pkg::SADC_SLEEP: begin
          if (enter_track) begin
            phase_q <= sadc_pkg::SADC_TRACK;
          end
        end
        sadc_pkg::SADC_TRACK: begin
          if (enter_hold) begin
            phase_q <= sadc_pkg::SADC_HOLD;
          end
        end
        sadc_pkg::SADC_HOLD: begin
          if (slot_end) begin
            phase_q <= sadc_pkg::SADC_SLEEP;
          end
        end
      endcase
    end
  end

  // ===========================================================
  // Channel selection: reset picks channel zero
  logic [2:0] chan_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      chan_q <= sadc_pkg::CHAN_RESET;
    end else if (enter_track) begin
      chan_q <= next_chan;
    end
  end

  // ===========================================================
  // Result capture and output shifter
  logic [7:0] result_q;
  logic dout_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_q <= 8'h00;
    end else if (enter_hold) begin
      result_q <= conv_result;
    end
  end

  // Bit launched on fall n uses post-increment count
  logic [4:0] next_fall;
  assign next_fall = start_now ? 5'h1 :
    (fall_cnt_q == 5'(sadc_pkg::SLOT_EDGES) ? 5'h1 :
     fall_cnt_q + 5'h1);

  always_ff @(posedge core_clk) begin
    if (rst || cs_n) begin
      dout_q <= 1'b0;
    end else if (start_now || f_fall) begin
      if (next_fall >= 5'(sadc_pkg::DATA_FIRST_FALL) &&
          next_fall <= 5'(sadc_pkg::DATA_LAST_FALL)) begin
        dout_q <= result_q[3'(sadc_pkg::DATA_LAST_FALL -
                              32'(next_fall))];
      end else begin
        dout_q <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Outputs
  assign dout_o = dout_q;
  assign dout_oe = ~cs_n;
  assign analog_input_channels = chan_q;
  assign track_en = phase_q == sadc_pkg::SADC_TRACK;
  assign hold_en = phase_q == sadc_pkg::SADC_HOLD;
  assign conv_start = enter_hold && phase_q == sadc_pkg::SADC_TRACK;
  assign powered_up = ~cs_n &&
    (phase_q == sadc_pkg::SADC_TRACK ||
     phase_q == sadc_pkg::SADC_HOLD);

endmodule

// ==== logic/sadc_pkg.sv ====
// Shared constants of the serial converter frame sequencer.
// Assumes a single core clock; serial pins sampled synchronously.
package sadc_pkg;

  // ===========================================================
  // Frame layout
  localparam int SLOT_EDGES = 16;
  localparam int TRACK_EDGES = 3;
  localparam int HOLD_EDGES = 13;
  localparam int HOLD_START_FALL = 4;
  localparam int DATA_FIRST_FALL = 5;
  localparam int DATA_LAST_FALL = 12;
  localparam int CTRL_BITS = 8;
  localparam int RESULT_BITS = 8;

  // ===========================================================
  // Control word fields
  localparam int CHAN_MSB = 5;
  localparam int CHAN_LSB = 3;
  localparam logic [2:0] CHAN_RESET = 3'h0;

  // ===========================================================
  // Sequencer phases
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_TRACK,
    SADC_HOLD,
    SADC_SLEEP
  } sadc_phase_t;

endpackage

// ==== testbench/sadc_frame_seq_sva.sv ====
// Timing checks on the converter sequencer ports.
// Assumes one core clock and synchronous active-high reset.
`timescale 1ns/10ps
module sadc_frame_seq_sva (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Reset
  input wire logic cs_n, // Chip select
  input wire logic dout_o, // Data out
  input wire logic dout_oe, // Data out enable
  input wire logic [2:0] analog_input_channels, // Channel
  input wire logic track_en, // Track phase
  input wire logic hold_en, // Hold phase
  input wire logic conv_start, // Hold start pulse
  input wire logic powered_up // Core powered
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_hold_soon;
    ##[0:1] hold_en;
  endsequence
  a_oe_follow_cs:
    assert property (dout_oe == !cs_n) else $error("oe wrong");
  a_idle_quiet:
    assert property (cs_n && $past(cs_n) |-> !track_en && !hold_en
      && !powered_up) else $error("active outside frame");
  a_power_phase:
    assert property (powered_up |-> !cs_n && (track_en || hold_en))
      else $error("powered in sleep");
  a_chan_held:
    assert property (hold_en && $past(hold_en)
      |-> $stable(analog_input_channels)) else $error("chan moved");
  a_track_zero:
    assert property (track_en |-> !dout_o) else $error("dout in track");
  a_phase_excl:
    assert property (!(track_en && hold_en)) else $error("both phases");
  a_start_pulse:
    assert property (conv_start |=> !conv_start) else $error("long start");
  a_start_hold:
    assert property (conv_start |-> s_hold_soon) else $error("no hold");
  a_hold_after_track:
    assert property ($rose(hold_en) |-> $past(track_en))
      else $error("hold without track");
endmodule
bind sadc_frame_seq sadc_frame_seq_sva i_sva (.core_clk(core_clk),
  .rst(rst), .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe),
  .analog_input_channels(analog_input_channels), .track_en(track_en),
  .hold_en(hold_en), .conv_start(conv_start), .powered_up(powered_up));

// ==== testbench/sadc_host_model.sv ====
// Host controller model driving chip select, clock and data in.
// Assumes pins are changed on core_clk rising edges.
`timescale 1ns/10ps
module sadc_host_model (
  input wire logic core_clk, // Core clock
  output logic cs_n, // Chip select
  output logic sclk, // Serial clock
  output logic din, // Data to device
  input wire logic dout_o // Data from device
);
  localparam int PH = 4;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  task automatic tick();
    repeat (PH) @(posedge core_clk);
  endtask
  // Mode 0 clock high, 1 clock low, 2 both fall together
  task automatic open_frame(input int mode);
    sclk <= (mode != 1);
    tick();
    cs_n <= 1'b0;
    if (mode == 2) sclk <= 1'b0;
    tick();
  endtask
  task automatic slot(input logic [7:0] ctrl, input bit skip,
    output logic [15:0] rx);
    for (int i = 0; i < 16; i++) begin
      if (!(skip && i == 0)) sclk <= 1'b0;
      din <= (i < 8) ? ctrl[7 - i] : ~din;
      tick();
      sclk <= 1'b1;
      rx[15 - i] = dout_o;
      tick();
    end
  endtask
  task automatic close_frame();
    cs_n <= 1'b1;
    din <= ~din;
    tick();
  endtask
endmodule

// ==== testbench/test_sadc_frame_seq.sv ====
// Self-checking bench of the converter sequencer.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/10ps
module test_sadc_frame_seq;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, din, dout_o, dout_oe, track_en, hold_en;
  logic conv_start, powered_up;
  logic [7:0] conv_result = 8'h00;
  logic [2:0] analog_input_channels;
  logic [2:0] cur_ch = 3'h0;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  // Analog core: code carries the sampled channel
  always @(posedge core_clk) conv_result <= {analog_input_channels, 5'h15};
  sadc_frame_seq i_dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
    .conv_result(conv_result), .analog_input_channels(analog_input_channels),
    .track_en(track_en), .hold_en(hold_en), .conv_start(conv_start),
    .powered_up(powered_up));
  sadc_host_model i_host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout_o(dout_o));
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic run_frame(input int mode, n, input logic [7:0] ctrl);
    logic [15:0] rx;
    i_host.open_frame(mode);
    check("oe frame", {15'h0, dout_oe}, 16'h1);
    for (int s = 0; s < n; s++) begin
      i_host.slot(s == 0 ? ctrl : ~ctrl, mode != 0 && s == 0, rx);
      check("slot word", rx, {4'h0, cur_ch, 5'h15, 4'h0});
      cur_ch = ctrl[5:3];
    end
    i_host.close_frame();
    check("oe idle", {15'h0, dout_oe}, 16'h0);
  endtask
  task automatic t_first_conv();
    run_frame(0, 1, 8'hEF);
    $display("first conversion done");
  endtask
  task automatic t_all_codes();
    for (int c = 0; c < 8; c++)
      run_frame(c % 3, 1, {2'h3, c[2:0], 3'h5});
    $display("channel codes done");
  endtask
  task automatic t_continuous();
    run_frame(1, 3, 8'h10);
    run_frame(2, 2, 8'h38);
    $display("continuous frames done");
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_first_conv();
    t_all_codes();
    t_continuous();
    final_report();
  end
endmodule
